// ### dv/sac_asserts.sv
// sac_asserts: wire-level checks on the link between host and converter.
// assumes: sits beside sac_link_if; rst is the converter's reset.
`default_nettype none

module sac_asserts (
  input wire logic rst,
  input wire logic cs_n,
  input wire logic serial_clock,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       act_q;   // start flag seen, frame running
  logic [4:0] edge_q;  // last rising edge index since start flag
  logic [5:0] low_q;   // rising edges seen with chip select low

  // frame tracker, edge 0 is the start-flag edge
  always_ff @(posedge serial_clock) begin
    if (rst || cs_n) begin
      act_q  <= 1'b0;
      edge_q <= 5'h00;
    end else if (!act_q) begin
      act_q  <= din;
      edge_q <= 5'h00;
    end else begin
      act_q  <= (edge_q != 5'h17);
      edge_q <= edge_q + 5'h01;
    end
  end

  // edge count per select window; no saturation, host ends frames
  always_ff @(posedge serial_clock) begin
    if (rst || cs_n) begin
      low_q <= 6'h00;
    end else begin
      low_q <= low_q + 6'h01;
    end
  end

  default clocking cb @(posedge serial_clock);
  endclocking
  default disable iff (rst);

  a_oe_follows_cs: assert property (dout_oe == !cs_n)
    else $error("dout enable does not follow chip select");
  a_released_low: assert property (cs_n |-> !dout)
    else $error("dout not released while deselected");
  a_frame_length: assert property ($rose(cs_n) |-> low_q == 6'h18)
    else $error("frame was not 24 clocks long");
  a_start_first: assert property ($fell(cs_n) |-> din)
    else $error("first control bit was not a start flag");
  a_spare_zero: assert property (act_q && edge_q == 5'h03 |-> !din)
    else $error("unused control bit not low");
  a_tail_din_zero: assert property (act_q && edge_q >= 5'h07 |-> !din)
    else $error("din active after the control byte");
  a_null_bit_low: assert property (act_q && edge_q == 5'h07 |-> !dout)
    else $error("null bit before result not low");
  a_tail_out_low: assert property (act_q && edge_q >= 5'h14 |-> !dout)
    else $error("dout not low in trailing clocks");
  a_idle_out_low: assert property (!act_q && !cs_n |-> !dout_o)
    else $error("dout active before start flag");
endmodule

`default_nettype wire

// ### dv/sar_adc_serial_control_sequencer_test.sv
// sar_adc_serial_control_sequencer_test: host and converter joined by the
// link, every channel, mode and power code converted at least once.
// assumes: an ideal comparator modelled from vin; default host divider.
`default_nettype none

module sar_adc_serial_control_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst;
  logic        conv_rst;
  logic        start;
  logic [2:0]  sel;        // {high, mid, low}
  logic        sgl;
  logic [1:0]  pd;
  logic [11:0] vin;        // analog input as an ideal code
  logic        busy;
  logic [11:0] result;
  logic        result_valid;
  logic        comp_above;
  logic [2:0]  mux_pos;
  logic [2:0]  mux_neg;
  logic        neg_is_common;
  logic        sample_acquire;
  logic        sample_hold;
  logic [11:0] sar_trial;
  logic        analog_powered;
  logic [1:0]  power_down_sel;
  logic [11:0] conv_result;
  logic        conv_result_valid;
  int          n_fail;
  int          compares;

  sac_link_if link();

  // ideal comparator: trial at or below the input
  assign comp_above = (vin >= sar_trial);

  sac_host u_sac_host (
    .clk                           (clk),
    .rst                           (rst),
    .link                          (link),
    .start                         (start),
    .chan_sel_high                 (sel[2]),
    .chan_sel_mid                  (sel[1]),
    .chan_sel_low                  (sel[0]),
    .single_or_differential_select (sgl),
    .power_down_sel_high           (pd[1]),
    .power_down_sel_low            (pd[0]),
    .busy                          (busy),
    .result                        (result),
    .result_valid                  (result_valid)
  );

  sac_converter u_sac_converter (
    .link              (link),
    .rst               (conv_rst),
    .comp_above        (comp_above),
    .mux_pos           (mux_pos),
    .mux_neg           (mux_neg),
    .neg_is_common     (neg_is_common),
    .sample_acquire    (sample_acquire),
    .sample_hold       (sample_hold),
    .sar_trial         (sar_trial),
    .analog_powered    (analog_powered),
    .power_down_sel    (power_down_sel),
    .conv_result       (conv_result),
    .conv_result_valid (conv_result_valid)
  );

  sac_asserts u_sac_asserts (
    .rst          (conv_rst),
    .cs_n         (link.cs_n),
    .serial_clock (link.serial_clock),
    .din          (link.din),
    .dout_o       (link.dout_o),
    .dout_oe      (link.dout_oe),
    .dout         (link.dout)
  );

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    n_fail++;
    $display("Error %s expected event seen timeout", what);
    stop_test();
  endtask

  // one conversion; select and mode inputs garbled while busy, so a second take would show
  task automatic convert_check(input logic [2:0] s, input logic m,
                               input logic [1:0] p, input logic [11:0] v);
    int n;
    int nv;
    n = 0;
    nv = 0;
    @(posedge clk);
    vin   <= v;
    sel   <= s;
    sgl   <= m;
    pd    <= p;
    start <= 1'b1;
    while (busy !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 4) timed_out("busy");
    end
    sel <= ~s;
    sgl <= ~m;
    repeat (2) @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (sample_acquire !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 400) timed_out("sample_acquire");
    end
    n = 0;
    // falls seen in acquisition before hold takes over
    @(negedge link.serial_clock);
    while (sample_hold !== 1'b1) begin
      n++;
      if (n > 8) timed_out("sample_hold");
      @(negedge link.serial_clock);
    end
    check("acq_clocks", 12'(n), 12'h003);
    check("acquire_off", {11'h000, sample_acquire}, 12'h000);
    check("mux_pos", {9'h000, mux_pos},
          {9'h000, s[1], s[0], s[2]});
    check("mux_neg", {9'h000, mux_neg},
          m ? 12'h000 : {9'h000, s[1], s[0], ~s[2]});
    check("neg_common", {11'h000, neg_is_common}, {11'h000, m});
    n = 0;
    // the converter's valid pulse spans one serial clock period
    while (result_valid !== 1'b1) begin
      @(posedge clk);
      n++;
      if (conv_result_valid === 1'b1) nv++;
      if (n > 1500) timed_out("result_valid");
    end
    check("conv_valid_len", 12'(nv),
          12'(2 * sac_pkg::SCLK_HALF_DEF));
    check("result", result, v);
    check("conv_result", conv_result, v);
    check("power_sel", {10'h000, power_down_sel}, {10'h000, p});
    check("powered", {11'h000, analog_powered},
          {11'h000, p == 2'h3});
  endtask

  // reset, then every channel in both modes, back to back
  initial begin
    rst      = 1'b1;
    conv_rst = 1'b1;
    start    = 1'b0;
    sel      = 3'h0;
    sgl      = 1'b0;
    pd       = 2'h0;
    vin      = 12'h000;
    n_fail   = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge link.serial_clock);
    // release away from a rising serial clock edge
    @(negedge link.serial_clock);
    @(posedge clk);
    conv_rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      convert_check(i[2:0], i[3], i[1:0], 12'(i) * 12'h111);
    end
    convert_check(3'h5, 1'b1, 2'h3, 12'h7FF);
    convert_check(3'h2, 1'b0, 2'h0, 12'h800);
    stop_test();
  end
endmodule

`default_nettype wire

// ### verilog/sac_converter.sv
// sac_converter: digital sequencer of a successive-approximation converter
// with an eight-input multiplexer, driven over a serial link.
// assumes: serial_clock comes from the host through the link, and rst is
// synchronous to it; the analog comparator settles within half a clock.
//
// How it works
// - eight-clock exchanges, three per conversion
// - host sends control byte first eight clocks
// - mux set, acquisition starts before byte ends
// - three clocks later: hold, start converting
// - twelve clocks, one bit decision each
// - thirteenth clock presents last result bit
// - three trailing clocks: output low, ignored
// - single-ended channel is mid*4+low*2+high
// - differential pair from mid/low, high picks polarity
// - straight binary code, step is reference/4096
// - input configuration only via serial control bits
// - byte order: start, selects, spare, mode, power
// - input ignored until high start flag
// - latch input rising edge, chip select low
// - shift output falling edge, released when deselected
`default_nettype none

module sac_converter #(
  parameter int RES = sac_pkg::RES_BITS
) (
  sac_link_if.conv          link,
  input  wire logic         rst,
  input  wire logic         comp_above,
  output logic [2:0]        mux_pos,
  output logic [2:0]        mux_neg,
  output logic              neg_is_common,
  output logic              sample_acquire,
  output logic              sample_hold,
  output logic [RES-1:0]    sar_trial,
  output logic              analog_powered,
  output logic [1:0]        power_down_sel,
  output logic [RES-1:0]    conv_result,
  output logic              conv_result_valid
);
  // decisions end by edge HOLD_EDGE+RES, which must leave the tail room
  if (RES < 2 || sac_pkg::HOLD_EDGE + RES > sac_pkg::FRAME_EDGES - 2)
  begin : g_chk
    $error("sac_converter: RES does not fit the 24-clock frame");
  end

  localparam int IW = $clog2(RES);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CTRL = 5'h02,
    ST_ACQ  = 5'h04,
    ST_CONV = 5'h08,
    ST_TAIL = 5'h10
  } sac_state_e;

  typedef struct packed {
    sac_state_e     st;
    logic [4:0]     edge_cnt;
    logic [6:0]     ctrl;
    logic [IW-1:0]  bit_idx;
    logic [RES-1:0] code;
    logic [2:0]     pos;
    logic [2:0]     neg;
    logic           neg_com;
    logic           acquire;
    logic           hold;
    logic [1:0]     pd;
    logic [RES-1:0] result;
    logic           result_valid;
  } sac_conv_s;

  localparam sac_conv_s CONV_RST = '{
    st:       ST_IDLE,
    edge_cnt: 5'h00,
    ctrl:     7'h00,
    bit_idx:  '0,
    code:     '0,
    pos:      3'h0,
    neg:      3'h0,
    neg_com:  1'b1,
    acquire:  1'b0,
    hold:     1'b0,
    pd:       sac_pkg::PD_BETWEEN,
    result:   '0,
    result_valid: 1'b0
  };

  localparam logic [4:0] E_MUX  = 5'(sac_pkg::MUX_SET_EDGE);
  localparam logic [4:0] E_PD   = 5'(sac_pkg::PD_EDGE);
  localparam logic [4:0] E_HOLD = 5'(sac_pkg::HOLD_EDGE);
  localparam logic [4:0] E_LAST = 5'(sac_pkg::FRAME_EDGES - 1);
  localparam logic [IW-1:0] TOP_BIT = IW'(RES - 1);

  // multiplexer routing: {pos, neg, neg_is_common}
  // positive index is mid*4+low*2+high in both modes; the differential
  // partner is the other channel of the same adjacent pair
  function automatic logic [6:0] mux_route(
    input logic hi,
    input logic mid,
    input logic lo,
    input logic single
  );
    logic [2:0] p;
    p = {mid, lo, hi};
    if (single) begin
      mux_route = {p, 3'h0, 1'b1};
    end else begin
      mux_route = {p, {mid, lo, ~hi}, 1'b0};
    end
  endfunction

  sac_conv_s q;
  sac_conv_s d;
  logic      dout_q;   // falling-edge output and bit decision
  logic      dout_d;

  // rising-edge sequencer
  always_comb begin
    logic [6:0] route;
    route = 7'h00;
    d = q;
    d.result_valid = 1'b0;
    if (rst) begin
      d = CONV_RST;
    end else if (link.cs_n) begin
      // deselect aborts any frame; the held sample is abandoned
      d.st      = ST_IDLE;
      d.acquire = 1'b0;
      d.hold    = 1'b0;
    end else begin
      if (q.st != ST_IDLE) begin
        d.edge_cnt = q.edge_cnt + 5'h01;
      end
      unique case (q.st)
        ST_IDLE: begin
          // low bits before the start flag are not part of a byte
          if (link.din) begin
            d.st       = ST_CTRL;
            d.edge_cnt = 5'h01;
          end
        end
        ST_CTRL: begin
          d.ctrl = {q.ctrl[5:0], link.din};
          if (q.edge_cnt == E_MUX) begin
            // ctrl[3:1] hold the selects, din is the mode bit
            route = mux_route(q.ctrl[3], q.ctrl[2], q.ctrl[1],
                              link.din);
            d.pos     = route[6:4];
            d.neg     = route[3:1];
            d.neg_com = route[0];
            d.acquire = 1'b1;
            d.st      = ST_ACQ;
          end
        end
        ST_ACQ: begin
          d.ctrl = {q.ctrl[5:0], link.din};
          if (q.edge_cnt == E_PD) begin
            d.pd = {q.ctrl[0], link.din};
          end
          if (q.edge_cnt == E_HOLD) begin
            // byte complete: freeze the sample, set msb trial
            d.acquire = 1'b0;
            d.hold    = 1'b1;
            d.bit_idx = TOP_BIT;
            d.code    = {1'b1, {(RES-1){1'b0}}};
            d.st      = ST_CONV;
          end
        end
        ST_CONV: begin
          // commit the decision taken on the last falling edge
          d.code[q.bit_idx] = dout_q;
          if (q.bit_idx == '0) begin
            d.result       = {q.code[RES-1:1], dout_q};
            d.result_valid = 1'b1;
            d.hold         = 1'b0;
            d.st           = ST_TAIL;
          end else begin
            d.code[q.bit_idx - IW'(1)] = 1'b1;
            d.bit_idx = q.bit_idx - IW'(1);
          end
        end
        ST_TAIL: begin
          // trailing clocks are counted out, din is not looked at
          if (q.edge_cnt == E_LAST) begin
            d.st = ST_IDLE;
          end
        end
        default: begin
          d = CONV_RST;
        end
      endcase
    end
  end

  always_ff @(posedge link.serial_clock) begin
    q <= d;
  end

  // falling edge: during conversion the comparator verdict is both the
  // bit decision and the output bit, so data leaves msb first with no
  // extra latency; everywhere else the output is held low
  always_comb begin
    if (rst) begin
      dout_d = 1'b0;
    end else if (q.st == ST_CONV) begin
      dout_d = comp_above;
    end else begin
      dout_d = 1'b0;
    end
  end

  always_ff @(negedge link.serial_clock) begin
    dout_q <= dout_d;
  end

  // output released whenever the converter is deselected
  assign link.dout_o  = dout_q;
  assign link.dout_oe = ~link.cs_n;

  assign mux_pos        = q.pos;
  assign mux_neg        = q.neg;
  assign neg_is_common  = q.neg_com;
  assign sample_acquire = q.acquire;
  assign sample_hold    = q.hold;
  assign sar_trial      = q.code;
  assign power_down_sel = q.pd;
  assign conv_result       = q.result;
  assign conv_result_valid = q.result_valid;

  // powered during acquisition and conversion, or always when power-down is off
  assign analog_powered = (q.pd == sac_pkg::PD_ALWAYS_ON) ||
                          (q.st == ST_ACQ) || (q.st == ST_CONV);
endmodule

`default_nettype wire

// ### verilog/sac_host.sv
// sac_host: serial master that runs one 24-clock conversion per request.
// assumes: the converter sits on the other side of sac_link_if; dout is
// resynchronised here because it changes on the converter's clock edge.
`default_nettype none

module sac_host #(
  parameter int RES       = sac_pkg::RES_BITS,
  parameter int SCLK_HALF = sac_pkg::SCLK_HALF_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  sac_link_if.host        link,
  input  wire logic       start,
  input  wire logic       chan_sel_high,
  input  wire logic       chan_sel_mid,
  input  wire logic       chan_sel_low,
  input  wire logic       single_or_differential_select,
  input  wire logic       power_down_sel_high,
  input  wire logic       power_down_sel_low,
  output logic            busy,
  output logic [RES-1:0]  result,
  output logic            result_valid
);
  // the half period must cover clock-high time, select setup and the
  // converter output delay plus the synchroniser
  if (SCLK_HALF < sac_pkg::T_CH_CYC || SCLK_HALF < sac_pkg::T_CSS_CYC ||
      SCLK_HALF < sac_pkg::SCLK_HALF_DEF || SCLK_HALF > 255 ||
      RES < 2 || RES > 12) begin : g_chk
    $error("sac_host: SCLK_HALF or RES out of range");
  end

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_ARM  = 3'h2,
    HS_RUN  = 3'h4
  } sac_hstate_e;

  typedef struct packed {
    sac_hstate_e    st;
    logic [7:0]     half_cnt;
    logic           sclk;
    logic           cs_n;
    logic           din;
    logic [4:0]     rise_idx;
    logic [7:0]     tx;
    logic [RES-1:0] rx;
    logic [RES-1:0] result;
    logic           valid;
  } sac_host_s;

  localparam logic [7:0] HALF_TOP   = 8'(SCLK_HALF - 1);
  localparam logic [4:0] RX_FIRST   = 5'(sac_pkg::HOLD_EDGE + 1);
  localparam logic [4:0] RX_LAST    = 5'(sac_pkg::HOLD_EDGE + RES);
  localparam logic [4:0] FRAME_DONE = 5'(sac_pkg::FRAME_EDGES);

  sac_host_s q;
  sac_host_s d;
  logic      dout_s;
  logic      tick;
  logic      rise_ev;
  logic      fall_ev;

  sac_sync2 #(.WIDTH(1)) u_dout_sync (
    .clk (clk),
    .rst (rst),
    .d   (link.dout),
    .q   (dout_s)
  );

  // the divider runs free outside reset; it must be cleared once because
  // an unknown count would never recover on its own
  assign tick    = (q.half_cnt == HALF_TOP);
  assign rise_ev = tick & ~q.sclk;
  assign fall_ev = tick & q.sclk;

  always_comb begin
    d = q;
    d.valid    = 1'b0;
    d.half_cnt = tick ? 8'h00 : q.half_cnt + 8'h01;
    d.sclk     = tick ? ~q.sclk : q.sclk;
    if (rst) begin
      d = '{st: HS_IDLE, half_cnt: 8'h00, sclk: 1'b0, cs_n: 1'b1,
            din: 1'b0, rise_idx: 5'h00, tx: 8'h00, rx: '0,
            result: '0, valid: 1'b0};
    end else begin
      unique case (q.st)
        HS_IDLE: begin
          // configuration reaches the converter only as control bits
          if (start) begin
            d.tx[sac_pkg::START_POS]    = 1'b1;
            d.tx[sac_pkg::SEL_HIGH_POS] = chan_sel_high;
            d.tx[sac_pkg::SEL_MID_POS]  = chan_sel_mid;
            d.tx[sac_pkg::SEL_LOW_POS]  = chan_sel_low;
            d.tx[3]                     = 1'b0;
            d.tx[sac_pkg::SGL_POS]      = single_or_differential_select;
            d.tx[sac_pkg::PD_HIGH_POS]  = power_down_sel_high;
            d.tx[sac_pkg::PD_LOW_POS]   = power_down_sel_low;
            d.st = HS_ARM;
          end
        end
        HS_ARM: begin
          // select falls with the clock low; a half period precedes
          // the first rising edge
          if (fall_ev) begin
            d.cs_n     = 1'b0;
            d.din      = q.tx[7];
            d.tx       = {q.tx[6:0], 1'b0};
            d.rise_idx = 5'h00;
            d.st       = HS_RUN;
          end
        end
        HS_RUN: begin
          if (rise_ev) begin
            d.rise_idx = q.rise_idx + 5'h01;
            if (q.rise_idx >= RX_FIRST && q.rise_idx <= RX_LAST) begin
              d.rx = {q.rx[RES-2:0], dout_s};
            end
          end
          // din changes only while the clock goes low
          if (fall_ev) begin
            if (q.rise_idx == FRAME_DONE) begin
              // tail clocks supplied; end the frame
              d.cs_n   = 1'b1;
              d.din    = 1'b0;
              d.result = q.rx;
              d.valid  = 1'b1;
              d.st     = HS_IDLE;
            end else begin
              d.din = q.tx[7];
              d.tx  = {q.tx[6:0], 1'b0};
            end
          end
        end
        default: begin
          d.st   = HS_IDLE;
          d.cs_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign link.serial_clock = q.sclk;
  assign link.cs_n         = q.cs_n;
  assign link.din          = q.din;
  assign busy              = (q.st != HS_IDLE);
  assign result            = q.result;
  assign result_valid      = q.valid;
endmodule

`default_nettype wire

// ### verilog/sac_link_if.sv
// sac_link_if: the four-wire serial link between host and converter.
// assumes: host makes serial_clock; the output wire is pulled low when
// nobody drives it.
`default_nettype none

interface sac_link_if;
  logic cs_n;          // chip select, active low
  logic serial_clock;  // link clock made by the host
  logic din;           // host to converter
  logic dout_o;        // converter output value
  logic dout_oe;       // converter drives dout
  logic dout;          // resolved wire level

  // released wire reads as the pull-down level
  assign dout = dout_oe ? dout_o : 1'b0;

  modport conv (
    input  cs_n,
    input  serial_clock,
    input  din,
    output dout_o,
    output dout_oe
  );

  modport host (
    output cs_n,
    output serial_clock,
    output din,
    input  dout
  );
endinterface

`default_nettype wire

// ### verilog/sac_pkg.sv
// sac_pkg: shared constants of the serial converter link and its two ends.
// assumes: both ends and the link interface are compiled after this file.
`default_nettype none

package sac_pkg;

  // control byte and frame framing
  localparam int CTRL_BITS    = 8;
  localparam int EXCHANGES    = 3;
  localparam int FRAME_EDGES  = CTRL_BITS * EXCHANGES;
  localparam int RES_BITS     = 12;
  localparam int FULL_SCALE   = 4096;

  // field positions inside the control byte, msb sent first
  localparam int START_POS    = 7;
  localparam int SEL_HIGH_POS = 6;
  localparam int SEL_MID_POS  = 5;
  localparam int SEL_LOW_POS  = 4;
  localparam int SGL_POS      = 2;
  localparam int PD_HIGH_POS  = 1;
  localparam int PD_LOW_POS   = 0;

  // rising edges counted from the start-flag edge (edge 0)
  localparam int MUX_SET_EDGE = CTRL_BITS - 1 - SGL_POS;
  localparam int ACQ_CYCLES   = 3;
  localparam int HOLD_EDGE    = MUX_SET_EDGE + ACQ_CYCLES;
  localparam int PD_EDGE      = CTRL_BITS - 1 - PD_LOW_POS;
  localparam int TAIL_EDGES   = 3;

  // power-down codes
  localparam logic [1:0] PD_BETWEEN   = 2'h0;
  localparam logic [1:0] PD_ALWAYS_ON = 2'h3;

  // host timing, least times rounded up to whole clk cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_CH_NS       = 200;
  localparam int T_CSS_NS      = 100;
  localparam int T_DO_NS       = 200;
  localparam int T_CH_CYC  = (T_CH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CSS_CYC = (T_CSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_DO_CYC  = (T_DO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC      = 3;
  localparam int SCLK_HALF_DEF = T_DO_CYC + SYNC_CYC;

endpackage

`default_nettype wire

// ### verilog/sac_sync2.sv
// sac_sync2: two-flop synchroniser for levels entering the clk domain.
// assumes: each bit is an independent level; no bus coherency.
`default_nettype none

module sac_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  if (WIDTH < 1) begin : g_chk
    $error("sac_sync2: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sac_sync_s;

  sac_sync_s s_q;
  sac_sync_s s_d;

  // first stage feeds only the second
  always_comb begin
    s_d.meta   = rst ? '0 : d;
    s_d.stable = rst ? '0 : s_q.meta;
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign q = s_q.stable;
endmodule

`default_nettype wire
